// ==== core/osd_window_control_regs.sv ====
`timescale 1ns/1ps
module osd_window_control_regs #(
  parameter int ROM_DEPTH = 4096,
  parameter int ROM_AW = 12
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Host register port
  input wire logic [15:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  // Display page RAM codes at the read address
  input wire logic [7:0] page_char_code,
  input wire logic [7:0] page_attr_code,
  // Font access
  output logic font_plane_sel,
  output logic [ROM_AW-1:0] rom_addr,
  output logic rom_rd_en,
  input wire logic [7:0] rom_data,
  // Frame timing
  input wire logic vsync_pulse,
  input wire logic hline_pulse,
  output logic vertical_blanking_output,
  output logic [osd_regs_pkg::HEIGHT_W-1:0] height_line_total,
  // Colours
  output logic [osd_regs_pkg::COLOUR_W-1:0] highlight_colour,
  output logic [osd_regs_pkg::COLOUR_W-1:0] lowlight_colour,
  output logic [osd_regs_pkg::COLOUR_W-1:0] shadow_colour,
  // Window enables and raster position
  input wire logic global_display_enable,
  input wire logic window_one_enable,
  input wire logic window_two_enable,
  input wire logic [osd_regs_pkg::HPIX_W-1:0] pixel_count,
  input wire logic [osd_regs_pkg::VLINE_W-1:0] char_line_count,
  input wire logic [6:0] char_column,
  input wire logic [4:0] col_pixel,
  // Window results
  output logic [osd_regs_pkg::HPIX_W-1:0] window_one_hstart_pix,
  output logic [osd_regs_pkg::VLINE_W-1:0] window_one_vstart_line,
  output logic window_one_active,
  output logic window_one_double,
  output logic [3:0] window_one_font_pixel,
  output logic [osd_regs_pkg::HPIX_W-1:0] window_two_hstart_pix,
  output logic window_two_active
);
  import osd_regs_pkg::*;

  // ----------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------
  logic code_sel;
  logic [VERTICAL_BLANKING_OUTPUT_W-1:0] vertical_blanking_output_len;
  logic [7:0] char_height;
  logic [7:0] win1_hstart;
  logic [7:0] win1_vstart;
  logic [31:0] win1_mask;
  logic [7:0] win2_hstart;
  logic sig_start_req;
  logic sig_busy;
  logic sig_done;
  logic [15:0] sig_result;
  logic [VERTICAL_BLANKING_OUTPUT_W-1:0] vertical_blanking_output_left;
  logic page_hit;
  logic [7:0] next_rdata;

  osd_window_if win1_if ();
  osd_window_if win2_if ();

  function automatic logic is_addr(input logic [15:0] a, input logic [15:0] target);
    return a == target;
  endfunction

  assign page_hit = (reg_addr >= ADDR_PAGE_FIRST) && (reg_addr <= ADDR_PAGE_LAST);
  assign sig_start_req = reg_wr && is_addr(reg_addr, ADDR_SIG_START) && reg_wdata[BIT_SIG_START];

  // ----------------------------------------------------------------
  // Host writes
  // ----------------------------------------------------------------
  // Only defined fields are stored, so reserved bits drop writes
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      font_plane_sel <= 1'b0;
      code_sel <= 1'b0;
      vertical_blanking_output_len <= '0;
      char_height <= RESET_BYTE;
    end
    else if (reg_wr)
    begin
      if (is_addr(reg_addr, ADDR_FONT_CODE_SEL))
      begin
        font_plane_sel <= reg_wdata[BIT_FONT_PLANE];
        code_sel <= reg_wdata[BIT_CODE_SEL];
      end
      if (is_addr(reg_addr, ADDR_VERTICAL_BLANKING_OUTPUT_LEN))
        vertical_blanking_output_len <= reg_wdata[VERTICAL_BLANKING_OUTPUT_W-1:0];
      if (is_addr(reg_addr, ADDR_CHAR_HEIGHT))
        char_height <= reg_wdata;
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      highlight_colour <= RESET_COLOUR;
      lowlight_colour <= RESET_COLOUR;
      shadow_colour <= RESET_COLOUR;
    end
    else if (reg_wr)
    begin
      // High byte keeps only bit 8 of each colour
      case (reg_addr)
        ADDR_HIGHLIGHT_LO: highlight_colour[7:0] <= reg_wdata;
        ADDR_HIGHLIGHT_HI: highlight_colour[8] <= reg_wdata[0];
        ADDR_LOWLIGHT_LO: lowlight_colour[7:0] <= reg_wdata;
        ADDR_LOWLIGHT_HI: lowlight_colour[8] <= reg_wdata[0];
        ADDR_SHADOW_LO: shadow_colour[7:0] <= reg_wdata;
        ADDR_SHADOW_HI: shadow_colour[8] <= reg_wdata[0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      win1_hstart <= RESET_BYTE;
      win1_vstart <= RESET_BYTE;
      win1_mask <= RESET_MASK;
      win2_hstart <= RESET_BYTE;
    end
    else if (reg_wr)
    begin
      // Values of two or less are accepted; the host is expected to avoid them
      if (is_addr(reg_addr, ADDR_WIN1_HSTART))
        win1_hstart <= reg_wdata;
      if (is_addr(reg_addr, ADDR_WIN1_VSTART))
        win1_vstart <= reg_wdata;
      if (is_addr(reg_addr, ADDR_WIN2_HSTART))
        win2_hstart <= reg_wdata;
      if (reg_addr >= ADDR_WIN1_MASK_B0 && reg_addr <= ADDR_WIN1_MASK_B3)
        win1_mask[8*reg_addr[1:0] +: 8] <= reg_wdata;
    end
  end

  // ----------------------------------------------------------------
  // Host reads
  // ----------------------------------------------------------------
  always_comb
  begin
    next_rdata = 8'h00;
    if (page_hit)
      next_rdata = code_sel ? page_attr_code : page_char_code;
    else
      case (reg_addr)
        ADDR_FONT_CODE_SEL: next_rdata = {6'h00, code_sel, font_plane_sel};
        ADDR_VERTICAL_BLANKING_OUTPUT_LEN: next_rdata = {1'b0, vertical_blanking_output_len};
        ADDR_CHAR_HEIGHT: next_rdata = char_height;
        ADDR_HIGHLIGHT_LO: next_rdata = highlight_colour[7:0];
        ADDR_HIGHLIGHT_HI: next_rdata = {7'h00, highlight_colour[8]};
        ADDR_LOWLIGHT_LO: next_rdata = lowlight_colour[7:0];
        ADDR_LOWLIGHT_HI: next_rdata = {7'h00, lowlight_colour[8]};
        ADDR_SHADOW_LO: next_rdata = shadow_colour[7:0];
        ADDR_SHADOW_HI: next_rdata = {7'h00, shadow_colour[8]};
        ADDR_SIG_START: next_rdata = {7'h00, sig_busy};
        ADDR_SIG_RESULT_LO: next_rdata = sig_result[7:0];
        ADDR_SIG_RESULT_HI: next_rdata = sig_result[15:8];
        ADDR_WIN1_HSTART: next_rdata = win1_hstart;
        ADDR_WIN1_VSTART: next_rdata = win1_vstart;
        ADDR_WIN2_HSTART: next_rdata = win2_hstart;
        default:
          if (reg_addr >= ADDR_WIN1_MASK_B0 && reg_addr <= ADDR_WIN1_MASK_B3)
            next_rdata = win1_mask[8*reg_addr[1:0] +: 8];
      endcase
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      reg_rdata <= 8'h00;
      reg_rvalid <= 1'b0;
    end
    else
    begin
      reg_rvalid <= reg_rd;
      if (reg_rd)
        reg_rdata <= next_rdata;
    end
  end

  // ----------------------------------------------------------------
  // Vertical blanking and character height
  // ----------------------------------------------------------------
  // A new sync restarts the count even mid-blank
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      vertical_blanking_output_left <= '0;
      vertical_blanking_output <= 1'b0;
    end
    else if (vsync_pulse)
    begin
      vertical_blanking_output_left <= vertical_blanking_output_len;
      vertical_blanking_output <= (vertical_blanking_output_len != '0);
    end
    else if (hline_pulse && vertical_blanking_output_left != '0)
    begin
      vertical_blanking_output_left <= vertical_blanking_output_left - 1'b1;
      vertical_blanking_output <= (vertical_blanking_output_left != VERTICAL_BLANKING_OUTPUT_W'(1));
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      height_line_total <= '0;
    else
      height_line_total <= HEIGHT_W'(char_height) << HEIGHT_SHIFT;
  end

  // ----------------------------------------------------------------
  // Font ROM signature
  // ----------------------------------------------------------------
  osd_rom_signature #(
    .ROM_DEPTH(ROM_DEPTH),
    .ROM_AW(ROM_AW)
  ) u_sig (
    .clk(clk),
    .nrst(nrst),
    .start(sig_start_req),
    .busy(sig_busy),
    .done(sig_done),
    .result(sig_result),
    .rom_addr(rom_addr),
    .rom_rd_en(rom_rd_en),
    .rom_data(rom_data)
  );

  // ----------------------------------------------------------------
  // Display windows
  // ----------------------------------------------------------------
  // Window two has no column mask here, so it always runs normal width
  assign win1_if.shown_en = global_display_enable && window_one_enable;
  assign win1_if.hstart = win1_hstart;
  assign win1_if.vstart = win1_vstart;
  assign win1_if.mask = win1_mask;
  assign win2_if.shown_en = global_display_enable && window_two_enable;
  assign win2_if.hstart = win2_hstart;
  assign win2_if.vstart = RESET_BYTE;
  assign win2_if.mask = RESET_MASK;

  osd_window_geom u_win1 (
    .clk(clk),
    .nrst(nrst),
    .pixel_count(pixel_count),
    .char_line_count(char_line_count),
    .char_column(char_column),
    .col_pixel(col_pixel),
    .wif(win1_if.win)
  );

  osd_window_geom u_win2 (
    .clk(clk),
    .nrst(nrst),
    .pixel_count(pixel_count),
    .char_line_count(char_line_count),
    .char_column(char_column),
    .col_pixel(col_pixel),
    .wif(win2_if.win)
  );

  assign window_one_hstart_pix = win1_if.hstart_pix;
  assign window_one_vstart_line = win1_if.vstart_line;
  assign window_one_active = win1_if.active;
  assign window_one_double = win1_if.double_col;
  assign window_one_font_pixel = win1_if.font_pixel;
  assign window_two_hstart_pix = win2_if.hstart_pix;
  assign window_two_active = win2_if.active;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_attr_readback: assert property (@(posedge clk) disable iff (!nrst)
    reg_rd && page_hit && code_sel |=> reg_rvalid && reg_rdata == $past(page_attr_code))
    else $error("page read ignored attribute select");
  a_char_readback: assert property (@(posedge clk) disable iff (!nrst)
    reg_rd && page_hit && !code_sel |=> reg_rdata == $past(page_char_code))
    else $error("page read ignored character select");
  a_plane_write: assert property (@(posedge clk) disable iff (!nrst)
    reg_wr && is_addr(reg_addr, ADDR_FONT_CODE_SEL) |=> font_plane_sel == $past(reg_wdata[0]))
    else $error("font plane select not stored");
  a_vertical_blanking_output_begin: assert property (@(posedge clk) disable iff (!nrst)
    vsync_pulse |=> vertical_blanking_output == ($past(vertical_blanking_output_len) != 0))
    else $error("blanking did not follow sync");
  a_vertical_blanking_output_one_line: assert property (@(posedge clk) disable iff (!nrst)
    hline_pulse && !vsync_pulse && vertical_blanking_output_left == VERTICAL_BLANKING_OUTPUT_W'(1) |=> !vertical_blanking_output)
    else $error("blanking ran past its last line");
  a_height_scale: assert property (@(posedge clk) disable iff (!nrst)
    reg_wr && is_addr(reg_addr, ADDR_CHAR_HEIGHT) |=> ##1 height_line_total == {$past(reg_wdata, 2), 2'b00})
    else $error("height total not four times value");
  a_colour_reserved: assert property (@(posedge clk) disable iff (!nrst)
    reg_rd && is_addr(reg_addr, ADDR_HIGHLIGHT_HI) |=> reg_rdata[7:1] == 7'h00)
    else $error("reserved colour bits read nonzero");
  a_sig_busy_set: assert property (@(posedge clk) disable iff (!nrst)
    sig_start_req && !sig_busy |=> sig_busy [*8])
    else $error("signature start did not hold");
  a_sig_result: assert property (@(posedge clk) disable iff (!nrst)
    $changed(sig_result) |-> sig_done && !sig_busy)
    else $error("signature result changed outside completion");
  a_sig_finish: assert property (@(posedge clk) disable iff (!nrst)
    $fell(sig_busy) |-> sig_done)
    else $error("start bit cleared before result stored");
  a_hstart_scale: assert property (@(posedge clk) disable iff (!nrst)
    reg_wr && is_addr(reg_addr, ADDR_WIN1_HSTART) |=> ##1
      window_one_hstart_pix == (HPIX_W'($past(reg_wdata, 2)) << 2) + 11'd30)
    else $error("horizontal start pixel wrong");
  a_vstart_scale: assert property (@(posedge clk) disable iff (!nrst)
    reg_wr && is_addr(reg_addr, ADDR_WIN1_VSTART) |=> ##1
      window_one_vstart_line == {1'b0, $past(reg_wdata, 2), 1'b0})
    else $error("vertical start line wrong");
  a_window_gate: assert property (@(posedge clk) disable iff (!nrst)
    !(global_display_enable && window_one_enable) |=> !window_one_active)
    else $error("window shown while disabled");
  a_wide_limit: assert property (@(posedge clk) disable iff (!nrst)
    window_one_double |-> $past(char_column) < 7'd32)
    else $error("column past thirty-two widened");
  a_wide_repeat: assert property (@(posedge clk) disable iff (!nrst)
    window_one_double |-> window_one_font_pixel == $past(col_pixel[4:1]))
    else $error("wide column did not repeat pixels");

  c_sig_done: cover property (@(posedge clk) disable iff (!nrst) sig_done);
  c_vertical_blanking_output_end: cover property (@(posedge clk) disable iff (!nrst) $fell(vertical_blanking_output));
  c_wide_col: cover property (@(posedge clk) disable iff (!nrst) window_one_double && window_one_active);
endmodule

// ==== core/osd_regs_pkg.sv ====
package osd_regs_pkg;

  // ----------------------------------------------------------------
  // Register byte addresses
  // ----------------------------------------------------------------
  localparam logic [15:0] ADDR_FONT_CODE_SEL = 16'h8402;
  localparam logic [15:0] ADDR_VERTICAL_BLANKING_OUTPUT_LEN = 16'h8403;
  localparam logic [15:0] ADDR_CHAR_HEIGHT = 16'h8404;
  localparam logic [15:0] ADDR_HIGHLIGHT_LO = 16'h8405;
  localparam logic [15:0] ADDR_HIGHLIGHT_HI = 16'h8406;
  localparam logic [15:0] ADDR_LOWLIGHT_LO = 16'h8407;
  localparam logic [15:0] ADDR_LOWLIGHT_HI = 16'h8408;
  localparam logic [15:0] ADDR_SHADOW_LO = 16'h8409;
  localparam logic [15:0] ADDR_SHADOW_HI = 16'h840A;
  localparam logic [15:0] ADDR_SIG_START = 16'h840D;
  localparam logic [15:0] ADDR_SIG_RESULT_LO = 16'h840E;
  localparam logic [15:0] ADDR_SIG_RESULT_HI = 16'h840F;
  localparam logic [15:0] ADDR_WIN1_HSTART = 16'h8410;
  localparam logic [15:0] ADDR_WIN1_VSTART = 16'h8411;
  localparam logic [15:0] ADDR_WIN1_MASK_B0 = 16'h8414;
  localparam logic [15:0] ADDR_WIN1_MASK_B3 = 16'h8417;
  localparam logic [15:0] ADDR_WIN2_HSTART = 16'h8418;
  localparam logic [15:0] ADDR_PAGE_FIRST = 16'h8000;
  localparam logic [15:0] ADDR_PAGE_LAST = 16'h81FF;

  // ----------------------------------------------------------------
  // Field layout and reset values
  // ----------------------------------------------------------------
  localparam int BIT_FONT_PLANE = 0;
  localparam int BIT_CODE_SEL = 1;
  localparam int BIT_SIG_START = 0;
  localparam int VERTICAL_BLANKING_OUTPUT_W = 7;
  localparam int COLOUR_W = 9;
  localparam int HEIGHT_W = 10;
  localparam int HPIX_W = 11;
  localparam int VLINE_W = 10;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [8:0] RESET_COLOUR = 9'h000;
  localparam logic [31:0] RESET_MASK = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Scaling and geometry
  // ----------------------------------------------------------------
  localparam int HEIGHT_SHIFT = 2;
  localparam int HSTART_SHIFT = 2;
  localparam logic [10:0] HSTART_OFFSET = 11'h01E;
  localparam int VSTART_SHIFT = 1;
  localparam int MASK_COLS = 32;
  localparam logic [4:0] COL_NARROW_PIX = 5'h0C;
  localparam logic [4:0] COL_WIDE_PIX = 5'h18;

  // ----------------------------------------------------------------
  // Signature
  // ----------------------------------------------------------------
  localparam logic [15:0] CRC_POLY = 16'h1021;
  localparam logic [15:0] CRC_INIT = 16'hFFFF;

  typedef enum logic [2:0] {
    SIG_IDLE = 3'b001,
    SIG_RUN = 3'b010,
    SIG_DRAIN = 3'b100
  } sig_state_e;

endpackage

// ==== core/osd_window_if.sv ====
`timescale 1ns/1ps
interface osd_window_if;
  import osd_regs_pkg::*;
  logic shown_en;
  logic [7:0] hstart;
  logic [7:0] vstart;
  logic [31:0] mask;
  logic [HPIX_W-1:0] hstart_pix;
  logic [VLINE_W-1:0] vstart_line;
  logic active;
  logic double_col;
  logic [3:0] font_pixel;

  modport cfg (output shown_en, hstart, vstart, mask,
               input hstart_pix, vstart_line, active, double_col, font_pixel);
  modport win (input shown_en, hstart, vstart, mask,
               output hstart_pix, vstart_line, active, double_col, font_pixel);
endinterface

// ==== core/osd_window_geom.sv ====
`timescale 1ns/1ps
module osd_window_geom (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Raster position
  input wire logic [osd_regs_pkg::HPIX_W-1:0] pixel_count,
  input wire logic [osd_regs_pkg::VLINE_W-1:0] char_line_count,
  input wire logic [6:0] char_column,
  input wire logic [4:0] col_pixel,
  // Window configuration and results
  osd_window_if.win wif
);
  import osd_regs_pkg::*;

  logic dbl;

  // Columns past the mask width are never widened
  assign dbl = (char_column < 7'(MASK_COLS)) && wif.mask[char_column[4:0]];

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      wif.hstart_pix <= '0;
      wif.vstart_line <= '0;
    end
    else
    begin
      wif.hstart_pix <= (HPIX_W'(wif.hstart) << HSTART_SHIFT) + HSTART_OFFSET;
      wif.vstart_line <= VLINE_W'(wif.vstart) << VSTART_SHIFT;
    end
  end

  // Vertical start compares against auto-height lines, not scan lines
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      wif.active <= 1'b0;
    else
      wif.active <= wif.shown_en && (pixel_count >= wif.hstart_pix) &&
                    (char_line_count >= wif.vstart_line);
  end

  // Wide columns show each font pixel on two neighbouring positions
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      wif.double_col <= 1'b0;
      wif.font_pixel <= 4'h0;
    end
    else
    begin
      wif.double_col <= dbl;
      wif.font_pixel <= dbl ? col_pixel[4:1] : col_pixel[3:0];
    end
  end
endmodule

// ==== core/osd_rom_signature.sv ====
`timescale 1ns/1ps
module osd_rom_signature #(
  parameter int ROM_DEPTH = 4096,
  parameter int ROM_AW = 12
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Control
  input wire logic start,
  output logic busy,
  output logic done,
  output logic [15:0] result,
  // Font ROM, one cycle read latency
  output logic [ROM_AW-1:0] rom_addr,
  output logic rom_rd_en,
  input wire logic [7:0] rom_data
);
  import osd_regs_pkg::*;

  function automatic logic [15:0] crc_byte(input logic [15:0] crc, input logic [7:0] d);
    logic [15:0] c;
    c = crc ^ {d, 8'h00};
    for (int i = 0; i < 8; i++)
      c = c[15] ? ((c << 1) ^ CRC_POLY) : (c << 1);
    return c;
  endfunction

  sig_state_e state;
  logic [15:0] crc;
  logic last_issued;
  logic data_valid;

  assign busy = (state != SIG_IDLE);

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state <= SIG_IDLE;
      rom_addr <= '0;
      rom_rd_en <= 1'b0;
      last_issued <= 1'b0;
    end
    else
    begin
      case (state)
        SIG_IDLE:
          if (start)
          begin
            state <= SIG_RUN;
            rom_addr <= '0;
            rom_rd_en <= 1'b1;
          end
        SIG_RUN:
          if (rom_addr == ROM_AW'(ROM_DEPTH - 1))
          begin
            state <= SIG_DRAIN;
            rom_rd_en <= 1'b0;
            last_issued <= 1'b1;
          end
          else
            rom_addr <= rom_addr + 1'b1;
        SIG_DRAIN:
        begin
          state <= SIG_IDLE;
          last_issued <= 1'b0;
        end
        default:
          state <= SIG_IDLE;
      endcase
    end
  end

  // Data arrives the cycle after each address is issued, so bytes are taken one cycle behind the read enable
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      crc <= CRC_INIT;
      result <= 16'h0000;
      done <= 1'b0;
      data_valid <= 1'b0;
    end
    else
    begin
      done <= 1'b0;
      data_valid <= rom_rd_en;
      if (state == SIG_IDLE && start)
        crc <= CRC_INIT;
      else if (data_valid)
      begin
        crc <= crc_byte(crc, rom_data);
        if (last_issued)
        begin
          result <= crc_byte(crc, rom_data);
          done <= 1'b1;
        end
      end
    end
  end
endmodule

// ==== verification/osd_font_rom_model.sv ====
`timescale 1ns/1ps
module osd_font_rom_model #(
  parameter int AW = 4
) (
  // Font ROM port
  input wire logic clk,
  input wire logic [AW-1:0] addr,
  input wire logic rd_en,
  output logic [7:0] data
);
  // Idle cycles toggle the data so stale bytes are never mistaken for reads
  always @(posedge clk)
    data <= rd_en ? 8'(addr * 8'h1D + 8'h35) : ~data;
endmodule

// ==== verification/osd_window_control_regs_test.sv ====
`timescale 1ns/1ps
module osd_window_control_regs_test;
  import osd_regs_pkg::*;
  logic clk = 0, nrst = 0, reg_wr = 0, reg_rd = 0, vsync_pulse = 0, hline_pulse = 0;
  logic global_display_enable = 0, window_one_enable = 0, window_two_enable = 0;
  logic [15:0] reg_addr = 0, crc;
  logic [7:0] reg_wdata = 0, page_char_code = 0, page_attr_code = 0, reg_rdata, rom_data, d;
  logic [HPIX_W-1:0] pixel_count = 0, window_one_hstart_pix, window_two_hstart_pix;
  logic [VLINE_W-1:0] char_line_count = 0, window_one_vstart_line;
  logic [HEIGHT_W-1:0] height_line_total;
  logic [COLOUR_W-1:0] highlight_colour, lowlight_colour, shadow_colour;
  logic [6:0] char_column = 0;
  logic [4:0] col_pixel = 0;
  logic [3:0] rom_addr, window_one_font_pixel;
  logic reg_rvalid, font_plane_sel, rom_rd_en, vertical_blanking_output;
  logic window_one_active, window_one_double, window_two_active;
  logic [31:0] seed = 84, r, m;
  int failures = 0, samples_checked = 0, cycles = 0;
  osd_window_control_regs #(.ROM_DEPTH(16), .ROM_AW(4)) i_dut (.*);
  osd_font_rom_model #(.AW(4)) i_rom (.clk(clk), .addr(rom_addr), .rd_en(rom_rd_en), .data(rom_data));
  initial
  begin
    forever #12.5 clk = ~clk;
  end
  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    samples_checked++;
    if (e !== g)
    begin
      $display("BAD %s expected %0h seen %0h", n, e, g);
      failures++;
    end
  endtask
  task automatic wr(logic [15:0] a, logic [7:0] v);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = v;
    reg_wr = 1;
    @(negedge clk);
    reg_wr = 0;
  endtask
  task automatic rd(logic [15:0] a, output logic [7:0] v);
    @(negedge clk);
    reg_addr = a;
    reg_rd = 1;
    @(negedge clk);
    reg_rd = 0;
    chk("rvalid", 1, reg_rvalid);
    v = reg_rdata;
  endtask
  task automatic rdc(string n, logic [15:0] a, logic [7:0] e);
    rd(a, d);
    chk(n, e, d);
  endtask
  task automatic results;
    if (failures == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // Whole run needs about 200 cycles
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      failures++;
      results;
    end
  end
  initial
  begin
    repeat (4) @(negedge clk);
    nrst = 1;
    rdc("reset", ADDR_HIGHLIGHT_LO, 8'h00);
    for (int s = 0; s < 4; s++)
    begin
      page_char_code = 8'(rnd());
      page_attr_code = 8'(rnd());
      wr(ADDR_FONT_CODE_SEL, 8'(s) | 8'hFC);
      rdc("select", ADDR_FONT_CODE_SEL, 8'(s));
      chk("plane", s & 1, font_plane_sel);
      rdc("page", ADDR_PAGE_FIRST + 16'(s), s > 1 ? page_attr_code : page_char_code);
    end
    for (int i = 0; i < 3; i++)
    begin
      r = rnd();
      wr(ADDR_HIGHLIGHT_LO + 16'(2 * i), r[7:0]);
      wr(ADDR_HIGHLIGHT_HI + 16'(2 * i), r[15:8]);
      rdc("colour_hi", ADDR_HIGHLIGHT_HI + 16'(2 * i), {7'h00, r[8]});
      chk("colour", r[8:0], 9'({shadow_colour, lowlight_colour, highlight_colour} >> (9 * i)));
    end
    wr(16'h8412, 8'hFF);
    rdc("unmapped", 16'h8412, 8'h00);
    wr(ADDR_VERTICAL_BLANKING_OUTPUT_LEN, 8'h83);
    rdc("vblen", ADDR_VERTICAL_BLANKING_OUTPUT_LEN, 8'h03);
    vsync_pulse = 1;
    @(negedge clk) vsync_pulse = 0;
    for (int k = 0; k < 3; k++)
    begin
      @(negedge clk);
      chk("vertical_blanking_output", 1, vertical_blanking_output);
      hline_pulse = 1;
      @(negedge clk) hline_pulse = 0;
    end
    @(negedge clk);
    chk("vertical_blanking_output", 0, vertical_blanking_output);
    r = rnd();
    wr(ADDR_CHAR_HEIGHT, r[7:0]);
    repeat (2) @(negedge clk);
    chk("height", r[7:0] * 4, height_line_total);
    r = rnd() % 253 + 3;
    m = rnd();
    wr(ADDR_WIN1_HSTART, r[7:0]);
    wr(ADDR_WIN1_VSTART, m[7:0]);
    wr(ADDR_WIN2_HSTART, 8'h03);
    for (int b = 0; b < 4; b++)
      wr(ADDR_WIN1_MASK_B0 + 16'(b), m[8*b+:8]);
    pixel_count = 11'(r[7:0] * 4 + 30);
    char_line_count = 10'(m[7:0] * 2);
    for (int e = 0; e < 8; e++)
    begin
      {global_display_enable, window_one_enable, window_two_enable} = 3'(e);
      repeat (2) @(negedge clk);
      chk("hpix", r[7:0] * 4 + 30, window_one_hstart_pix);
      chk("hpix2", 3 * 4 + 30, window_two_hstart_pix);
      chk("vline", m[7:0] * 2, window_one_vstart_line);
      chk("act1", e[2] & e[1], window_one_active);
      chk("act2", e[2] & e[0], window_two_active);
    end
    for (int c = 0; c < 40; c++)
    begin
      char_column = 7'(c);
      col_pixel = 5'(rnd() % 24);
      repeat (2) @(negedge clk);
      d = (c < 32 && m[c % 32]) ? {3'h0, col_pixel} >> 1 : {4'h0, col_pixel[3:0]};
      chk("double", c < 32 && m[c % 32], window_one_double);
      chk("fontpix", d, window_one_font_pixel);
    end
    wr(ADDR_SIG_START, 8'h01);
    rdc("busy", ADDR_SIG_START, 8'h01);
    crc = CRC_INIT;
    for (int a = 0; a < 16; a++)
    begin
      d = 8'(a * 8'h1D + 8'h35);
      for (int k = 7; k >= 0; k--)
        crc = {crc[14:0], 1'b0} ^ ((crc[15] ^ d[k]) ? CRC_POLY : 16'h0000);
    end
    for (int t = 0; t < 40 && d !== 8'h00; t++)
      rd(ADDR_SIG_START, d);
    chk("done", 0, d);
    rdc("crc_lo", ADDR_SIG_RESULT_LO, crc[7:0]);
    rdc("crc_hi", ADDR_SIG_RESULT_HI, crc[15:8]);
    results;
  end
endmodule
